//--- tws_pkg.sv
// Shared constants and types for the two-wire slave block
package tws_pkg;
   // ----------------------------------------------------------------
   // Register word offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [1:0] REG_DATA = 2'h0; // Byte address 0x00
   localparam logic [1:0] REG_STATUS = 2'h1; // Byte address 0x04
   localparam logic [1:0] REG_ADDR = 2'h2; // Byte address 0x08
   localparam logic [1:0] REG_CTRL = 2'h3; // Byte address 0x0C
   // Control bit positions
   localparam int CB_FLAG = 7;
   localparam int CB_ACK = 6;
   localparam int CB_STA = 5;
   localparam int CB_STO = 4;
   localparam int CB_WC = 3;
   localparam int CB_EN = 2;
   localparam int CB_IE = 0;
   // Reset values
   localparam logic [7:0] RST_ADDR = 8'h00;
   localparam logic [7:0] RST_DATA = 8'hFF;
   // Status codes
   localparam logic [7:0] ST_NONE = 8'hF8;
   localparam logic [7:0] ST_RX_OWN = 8'h60;
   localparam logic [7:0] ST_RX_OWN_ARB = 8'h68;
   localparam logic [7:0] ST_RX_GC = 8'h70;
   localparam logic [7:0] ST_RX_GC_ARB = 8'h78;
   localparam logic [7:0] ST_RX_ACK = 8'h80;
   localparam logic [7:0] ST_RX_NACK = 8'h88;
   localparam logic [7:0] ST_GC_ACK = 8'h90;
   localparam logic [7:0] ST_GC_NACK = 8'h98;
   localparam logic [7:0] ST_STOP = 8'hA0;
   localparam logic [7:0] ST_TX_OWN = 8'hA8;
   localparam logic [7:0] ST_TX_ARB = 8'hB0;
   localparam logic [7:0] ST_TX_ACK = 8'hB8;
   localparam logic [7:0] ST_TX_NACK = 8'hC0;
   localparam logic [7:0] ST_TX_LAST = 8'hC8;
   // Bits in one byte on the wire
   localparam logic [3:0] BYTE_BITS = 4'h8;
   // Slave sequencer states
   typedef enum logic [2:0] {
      S_IDLE, S_ADDR, S_ADDR_ACK, S_RX, S_RX_ACK, S_TX, S_TX_ACK, S_DONE
   } tws_state_t;
endpackage : tws_pkg

//--- tws_line_if.sv
// Conditioned two-wire line levels and events between sampler and slave
`timescale 1ns/10ps
`default_nettype none
interface tws_line_if;
   logic scl; // Synchronised clock line level
   logic sda; // Synchronised data line level
   logic scl_rise; // One-cycle pulse on clock rising edge
   logic scl_fall; // One-cycle pulse on clock falling edge
   logic start; // START or repeated START seen
   logic stop; // STOP seen
   modport src (output scl, sda, scl_rise, scl_fall, start, stop);
   modport dst (input scl, sda, scl_rise, scl_fall, start, stop);
endinterface : tws_line_if
`default_nettype wire

//--- tws_line_sampler.sv
// Pin synchroniser and edge / condition detector for the two-wire bus
`timescale 1ns/10ps
`default_nettype none
module tws_line_sampler (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Raw pins
   input wire logic scl_in,
   input wire logic sda_in,
   // Conditioned line
   tws_line_if.src line
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [1:0] scl_s; // Two-flop synchroniser, bit 1 is the safe one
      logic [1:0] sda_s;
      logic scl_p; // Previous safe levels
      logic sda_p;
   } tws_samp_t;
   tws_samp_t st, next_st;
   // Next state: shift pins in, remember last safe level
   always_comb begin
      next_st = st;
      next_st.scl_s = {st.scl_s[0], scl_in};
      next_st.sda_s = {st.sda_s[0], sda_in};
      next_st.scl_p = st.scl_s[1];
      next_st.sda_p = st.sda_s[1];
   end
   // Registers, idle bus reads high
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         st <= '1;
      end else begin
         st <= next_st;
      end
   end
   // Events only from synchronised levels
   assign line.scl = st.scl_s[1];
   assign line.sda = st.sda_s[1];
   assign line.scl_rise = st.scl_s[1] & ~st.scl_p;
   assign line.scl_fall = ~st.scl_s[1] & st.scl_p;
   assign line.start = st.scl_s[1] & st.scl_p & st.sda_p & ~st.sda_s[1];
   assign line.stop = st.scl_s[1] & st.scl_p & ~st.sda_p & st.sda_s[1];
endmodule : tws_line_sampler
`default_nettype wire

//--- tws_slave.sv
// Two-wire slave receiver/transmitter with AHB-Lite register port
// Notes on behaviour
// - General-call byte acked gives 0x90, next ack follows ack_enable
// - General-call byte nacked gives 0x98, then unaddressed
// - STOP or repeated START while addressed gives 0xA0
// - start_request on leaving issues START when bus free
// - Unaddressed: ack_enable gates own and general-call match
// - Address bits 7:1 own address, bit 0 general call
// - Direction bit one selects transmit, else receive
// - After address, flag set with valid status
// - Arbitration lost then own read gives 0xB0
// - ack_enable cleared sends last byte, then 0xC0/0xC8
// - After last byte ignore clocks, data line released
// - ack_enable zero hides address, bus still watched
// - Deep sleep still matches address and requests wake
// - Clock held low after wake until flag cleared
// - Data register need not hold byte after wake
// - Own read acked gives 0xA8, then send data register
// - Transmitted byte acked gives 0xB8, then send next
//
// Added by the designer: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module tws_slave (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Two-wire pins, enable high pulls the line low
   input wire logic scl_in,
   output logic scl_oe,
   input wire logic sda_in,
   output logic sda_oe,
   // Neighbouring master logic and power control
   input wire logic arb_lost,
   input wire logic deep_sleep,
   output logic start_issue,
   output logic wake_req
);
   import tws_pkg::*;

   // ----------------------------------------------------------------
   // Line conditioning
   // ----------------------------------------------------------------
   tws_line_if line ();
   tws_line_sampler u_samp (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .line(line)
   );

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      tws_state_t state; // Sequencer state
      logic [3:0] cnt; // Bit counter
      logic [7:0] shift; // Shift register
      logic [7:0] data; // Data register
      logic [7:0] addr; // Address register
      logic [7:0] code; // Status code
      logic [1:0] presc; // Prescaler bits of status
      logic flag; // Completion flag
      logic ack_en; // ack_enable
      logic sta; // start_request
      logic sto; // stop_request
      logic wc; // write_collision
      logic en; // interface_enable
      logic ie; // irq_enable
      logic gc; // Addressed by general call
      logic rd; // Direction bit of address
      logic arb; // Arbitration lost at address time
      logic last; // Current byte is the last one
      logic mack; // Master ack sampled
      logic busy; // Bus between START and STOP
      logic start_pend; // START queued
      logic start_issue; // START request pulse
      logic scl_oe; // Clock stretch
      logic sda_oe; // Data line pulled low
      logic wake; // Wake request
      logic a_sel; // AHB data phase pending
      logic a_wr; // Pending phase is a write
      logic a_ok; // Pending address is mapped
      logic [1:0] a_idx; // Pending register index
      logic [31:0] hrdata; // Read data
   } tws_st_t;

   tws_st_t st, next_st;
   logic a_phase; // Address phase accepted
   logic [7:0] rd_mux; // Register read value
   logic clr_flag; // Software writes one to the flag
   logic own_hit; // Own address match
   logic gc_hit; // General call match
   logic addressed; // In an addressed transfer

   // Address phase and read mux
   always_comb begin
      a_phase = hsel & htrans[1] & hready;
      case (haddr[3:2])
         REG_DATA: rd_mux = st.data;
         REG_STATUS: rd_mux = {st.code[7:3], 1'b0, st.presc};
         REG_ADDR: rd_mux = st.addr;
         REG_CTRL: rd_mux = {st.flag, st.ack_en, st.sta, st.sto, st.wc, st.en, 1'b0, st.ie};
         default: rd_mux = 8'h00;
      endcase
      if (haddr[31:4] != 28'h000_0000) begin
         rd_mux = 8'h00;
      end
   end

   // Address matching against the shifted byte
   always_comb begin
      own_hit = st.ack_en & (st.shift[7:1] == st.addr[7:1]);
      gc_hit = st.ack_en & st.addr[0] & (st.shift == 8'h00);
      addressed = (st.state == S_RX) | (st.state == S_RX_ACK) |
         (st.state == S_TX) | (st.state == S_TX_ACK);
      clr_flag = st.a_sel & st.a_wr & st.a_ok & (st.a_idx == REG_CTRL) & hwdata[CB_FLAG];
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.start_issue = 1'b0;
      // AHB address phase, read data captured now
      next_st.a_sel = a_phase;
      if (a_phase) begin
         next_st.a_wr = hwrite;
         next_st.a_idx = haddr[3:2];
         next_st.a_ok = (haddr[31:4] == 28'h000_0000);
         if (!hwrite) begin
            next_st.hrdata = {24'h00_0000, rd_mux};
         end
      end
      // AHB data phase writes
      if (st.a_sel && st.a_wr && st.a_ok) begin
         case (st.a_idx)
            REG_DATA: begin
               // Writing data while the flag is low is a collision
               if (st.flag) begin
                  next_st.data = hwdata[7:0];
               end else begin
                  next_st.wc = 1'b1;
               end
            end
            REG_STATUS: next_st.presc = hwdata[1:0];
            REG_ADDR: next_st.addr = hwdata[7:0];
            REG_CTRL: begin
               next_st.ack_en = hwdata[CB_ACK];
               next_st.sta = hwdata[CB_STA];
               next_st.sto = hwdata[CB_STO];
               next_st.en = hwdata[CB_EN];
               next_st.ie = hwdata[CB_IE];
               if (hwdata[CB_FLAG]) begin
                  next_st.flag = 1'b0;
                  next_st.code = ST_NONE;
                  next_st.wake = 1'b0;
                  next_st.wc = 1'b0;
                  // Leaving to not-addressed mode may queue a START
                  if ((st.state == S_DONE || st.state == S_IDLE) && hwdata[CB_STA]) begin
                     next_st.start_pend = 1'b1;
                  end
                  if (st.state == S_DONE) begin
                     next_st.state = S_IDLE;
                  end
                  // Transmit: load byte and drive its first bit
                  if (st.state == S_TX && st.cnt == 4'h0) begin
                     next_st.shift = st.data;
                     next_st.last = ~hwdata[CB_ACK];
                     next_st.sda_oe = ~st.data[7];
                  end
               end
            end
            default: next_st.en = st.en;
         endcase
      end
      // Queued START goes out once the bus is free
      if (st.start_pend && !st.busy) begin
         next_st.start_pend = 1'b0;
         next_st.start_issue = 1'b1;
         next_st.sta = 1'b0;
      end
      // Line events, these win over a same-cycle flag clear
      if (line.start) begin
         next_st.busy = 1'b1;
         if (addressed) begin
            next_st.flag = 1'b1;
            next_st.code = ST_STOP;
         end
         next_st.state = S_ADDR;
         next_st.cnt = 4'h0;
         next_st.sda_oe = 1'b0;
      end else if (line.stop) begin
         next_st.busy = 1'b0;
         if (addressed) begin
            next_st.flag = 1'b1;
            next_st.code = ST_STOP;
         end
         next_st.state = S_IDLE;
         next_st.sda_oe = 1'b0;
      end else if (line.scl_rise) begin
         case (st.state)
            // Receive side samples data on the rising edge
            S_ADDR, S_RX: begin
               next_st.shift = {st.shift[6:0], line.sda};
               next_st.cnt = st.cnt + 4'h1;
            end
            S_TX: next_st.cnt = st.cnt + 4'h1;
            S_TX_ACK: next_st.mack = ~line.sda;
            default: next_st.cnt = st.cnt;
         endcase
      end else if (line.scl_fall) begin
         case (st.state)
            S_ADDR: begin
               if (st.cnt == BYTE_BITS) begin
                  if (own_hit || gc_hit) begin
                     next_st.gc = gc_hit & ~own_hit;
                     next_st.rd = st.shift[0] & ~(gc_hit & ~own_hit);
                     next_st.arb = arb_lost;
                     next_st.wake = deep_sleep;
                     next_st.sda_oe = 1'b1;
                     next_st.state = S_ADDR_ACK;
                  end else begin
                     next_st.state = S_IDLE;
                  end
               end
            end
            S_ADDR_ACK: begin
               next_st.sda_oe = 1'b0;
               next_st.flag = 1'b1;
               next_st.cnt = 4'h0;
               if (st.rd) begin
                  next_st.state = S_TX;
                  next_st.code = st.arb ? ST_TX_ARB : ST_TX_OWN;
               end else begin
                  next_st.state = S_RX;
                  if (st.gc) begin
                     next_st.code = st.arb ? ST_RX_GC_ARB : ST_RX_GC;
                  end else begin
                     next_st.code = st.arb ? ST_RX_OWN_ARB : ST_RX_OWN;
                  end
               end
            end
            S_RX: begin
               if (st.cnt == BYTE_BITS) begin
                  // byte kept here, a wake does not refresh it
                  next_st.data = st.shift;
                  next_st.sda_oe = st.ack_en;
                  next_st.last = ~st.ack_en;
                  next_st.state = S_RX_ACK;
               end
            end
            S_RX_ACK: begin
               next_st.sda_oe = 1'b0;
               next_st.flag = 1'b1;
               next_st.cnt = 4'h0;
               if (st.gc) begin
                  next_st.code = st.last ? ST_GC_NACK : ST_GC_ACK;
               end else begin
                  next_st.code = st.last ? ST_RX_NACK : ST_RX_ACK;
               end
               next_st.state = st.last ? S_DONE : S_RX;
            end
            S_TX: begin
               if (st.cnt == BYTE_BITS) begin
                  next_st.sda_oe = 1'b0;
                  next_st.state = S_TX_ACK;
               end else if (st.cnt != 4'h0) begin
                  next_st.shift = {st.shift[6:0], 1'b1};
                  next_st.sda_oe = ~st.shift[6];
               end
            end
            S_TX_ACK: begin
               next_st.flag = 1'b1;
               next_st.cnt = 4'h0;
               if (!st.mack) begin
                  next_st.code = ST_TX_NACK;
                  next_st.state = S_DONE;
               end else if (st.last) begin
                  next_st.code = ST_TX_LAST;
                  next_st.state = S_DONE;
               end else begin
                  next_st.code = ST_TX_ACK;
                  next_st.state = S_TX;
               end
            end
            default: next_st.sda_oe = 1'b0;
         endcase
      end
      // Disabled unit leaves the bus alone
      if (!st.en) begin
         next_st.state = S_IDLE;
         next_st.sda_oe = 1'b0;
      end
      // Hold clock low in S_RX or S_TX while the flag waits for software
      next_st.scl_oe = next_st.flag & st.en &
         ((next_st.state == S_RX) | (next_st.state == S_TX)) &
         (st.scl_oe | ~line.scl);
   end

   // Registers
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         st <= '0;
         st.state <= S_IDLE;
         st.code <= ST_NONE;
         st.addr <= RST_ADDR;
         st.data <= RST_DATA;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign hrdata = st.hrdata;
   assign hreadyout = 1'b1; // Zero-wait slave
   assign hresp = 1'b0;
   assign scl_oe = st.scl_oe;
   assign sda_oe = st.sda_oe;
   assign start_issue = st.start_issue;
   assign wake_req = st.wake;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_gc_ack_code: assert property (@(posedge core_clk) disable iff (!rst_b)
      (st.state == S_RX_ACK && st.gc && line.scl_fall && !line.start && !line.stop && st.en)
      |=> (st.code == (st.last ? ST_GC_NACK : ST_GC_ACK)) && st.flag)
      else $error("general call data status wrong");
   a_nack_done: assert property (@(posedge core_clk) disable iff (!rst_b)
      (st.state == S_DONE && clr_flag && !line.start && !line.stop && st.en)
      |=> st.state == S_IDLE)
      else $error("not-addressed mode not entered on clear");
   a_stop_code: assert property (@(posedge core_clk) disable iff (!rst_b)
      (addressed && line.stop) |=> st.flag && st.code == ST_STOP && st.state == S_IDLE)
      else $error("stop while addressed not reported");
   a_start_free: assert property (@(posedge core_clk) disable iff (!rst_b)
      st.start_issue |-> $past(st.start_pend) && !$past(st.busy))
      else $error("start issued while bus busy");
   a_ack_gate: assert property (@(posedge core_clk) disable iff (!rst_b)
      ($rose(st.sda_oe) && st.state == S_ADDR_ACK) |-> $past(st.ack_en))
      else $error("address acked with ack disabled");
   a_gc_enable: assert property (@(posedge core_clk) disable iff (!rst_b)
      (st.state == S_ADDR_ACK && st.gc) |-> st.addr[0] && st.shift == 8'h00)
      else $error("general call accepted while disabled");
   a_dir_mode: assert property (@(posedge core_clk) disable iff (!rst_b)
      (st.state == S_ADDR_ACK && line.scl_fall && !line.start && !line.stop && st.en)
      |=> st.state == (st.rd ? S_TX : S_RX))
      else $error("direction bit selects wrong mode");
   a_arb_code: assert property (@(posedge core_clk) disable iff (!rst_b)
      ($rose(st.flag) && st.code == ST_TX_ARB) |-> st.arb && st.rd)
      else $error("0xB0 without lost arbitration");
   a_last_code: assert property (@(posedge core_clk) disable iff (!rst_b)
      ($rose(st.flag) && st.code == ST_TX_LAST) |-> $past(st.last) && st.state == S_DONE)
      else $error("0xC8 without last byte");
   a_done_release: assert property (@(posedge core_clk) disable iff (!rst_b)
      (st.state == S_DONE) |-> !st.sda_oe && !st.scl_oe)
      else $error("line driven after last byte");
   a_wake_flag: assert property (@(posedge core_clk) disable iff (!rst_b)
      ($rose(st.wake)) |-> st.state == S_ADDR_ACK ##1 st.wake [*1])
      else $error("wake request without address match");
   a_stretch_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
      (st.scl_oe && st.flag && !clr_flag && !line.start && !line.stop) |=> st.scl_oe)
      else $error("clock stretch dropped before clear");
endmodule : tws_slave
`default_nettype wire

//--- tws_master_model.sv
// Behavioural two-wire bus master that clocks the line at 80 ns
`timescale 1ns/10ps
`default_nettype none
module tws_master_model (
   // Resolved line levels
   input wire logic scl,
   input wire logic sda,
   // Pull-down requests, high pulls the line low
   output logic scl_low,
   output logic sda_low
);
   // ----------------------------------------------------------------
   // Line primitives
   // ----------------------------------------------------------------
   // Both lines released at start, pull-ups give idle high
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end
   // One clock pulse: data changes well after the fall, sampled while high
   task automatic clk_bit(input logic b, output logic r);
      #10;
      sda_low = !b;
      #30;
      scl_low = 1'b0;
      wait (scl === 1'b1); // Waits while the slave stretches
      #20;
      r = sda;
      #20;
      scl_low = 1'b1;
   endtask : clk_bit
   // Data falls while clock is high
   task automatic start_c;
      sda_low = 1'b1;
      #40;
      scl_low = 1'b1;
   endtask : start_c
   // Data rises while clock is high, then the bus is free
   task automatic stop_c;
      #10;
      sda_low = 1'b1;
      #30;
      scl_low = 1'b0;
      wait (scl === 1'b1);
      #40;
      sda_low = 1'b0;
      #40;
   endtask : stop_c
   // Eight bits MSB first, then the acknowledge bit
   task automatic xfer(input logic [7:0] tx, input logic ak, output logic [7:0] rx,
                       output logic ako);
      for (int i = 7; i >= 0; i--) clk_bit(tx[i], rx[i]);
      clk_bit(ak, ako);
   endtask : xfer
endmodule : tws_master_model
`default_nettype wire

//--- tb_two_wire_slave_rx_tx.sv
// Self-checking testbench for the two-wire slave block
`timescale 1ns/10ps
`default_nettype none
module tb_two_wire_slave_rx_tx;
   import tws_pkg::*;
   logic core_clk, rst_b, hsel, hwrite, hready, hresp, hreadyout;
   logic scl, sda, scl_oe, sda_oe, arb_lost, deep_sleep, start_issue, wake_req;
   logic m_scl_low, m_sda_low, ak, started;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, seed;
   logic [7:0] v, rx, d;
   logic [6:0] own;
   int fail_count, cmp_count;
   // Open-drain wires with pull-ups
   assign scl = !(scl_oe | m_scl_low);
   assign sda = !(sda_oe | m_sda_low);
   assign hready = hreadyout;
   tws_slave tws_slave_i (.core_clk(core_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .scl_in(scl), .scl_oe(scl_oe),
      .sda_in(sda), .sda_oe(sda_oe), .arb_lost(arb_lost), .deep_sleep(deep_sleep),
      .start_issue(start_issue), .wake_req(wake_req));
   tws_master_model tws_master_model_i (.scl(scl), .sda(sda), .scl_low(m_scl_low),
      .sda_low(m_sda_low));
   // Clock at 125 MHz
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = !core_clk;
   end
   // Catches the queued START pulse
   always @(posedge core_clk) if (start_issue === 1'b1) started <= 1'b1;
   // Byte address of a register index
   function automatic logic [31:0] ra(input logic [1:0] r);
      return {28'h000_0000, r, 2'b00};
   endfunction : ra
   // One single AHB-Lite transfer, answer taken at the edge hready is high
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [7:0] wd,
                      output logic [7:0] rd);
      @(posedge core_clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= wr;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h00_0000, wd};
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      rd = hrdata[7:0];
      // Return off the edge so the write is visible to the caller
      @(negedge core_clk);
   endtask : ahb
   task automatic wr(input logic [1:0] r, input logic [7:0] wd);
      logic [7:0] x;
      ahb(1'b1, ra(r), wd, x);
   endtask : wr
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Polls the completion flag, then compares the masked status
   task automatic flag_status(input logic [7:0] exp);
      int n;
      n = 0;
      v = 8'h00;
      while (v[CB_FLAG] !== 1'b1 && n < 100) begin
         ahb(1'b0, ra(REG_CTRL), 8'h00, v);
         n++;
      end
      check({7'h00, v[CB_FLAG]}, 8'h01);
      ahb(1'b0, ra(REG_STATUS), 8'h00, v);
      check(v & 8'hF8, exp);
   endtask : flag_status
   task automatic print_verdict;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : print_verdict
   // Watchdog well beyond the expected run
   initial begin
      #400_000;
      fail_count++;
      print_verdict();
   end
   // Main sequence
   initial begin
      seed = 32'h2fd0;
      {hsel, hwrite, htrans, haddr, hwdata, arb_lost, deep_sleep, started} = '0;
      hsize = 3'h2;
      fail_count = 0;
      cmp_count = 0;
      rst_b = 1'b0;
      repeat (8) @(posedge core_clk);
      rst_b <= 1'b1;
      // Reset values and an unmapped address
      ahb(1'b0, ra(REG_STATUS), 8'h00, v); check(v, ST_NONE);
      ahb(1'b0, ra(REG_DATA), 8'h00, v); check(v, RST_DATA);
      ahb(1'b0, ra(REG_CTRL), 8'h00, v); check(v, 8'h00);
      ahb(1'b1, 32'h0000_0010, 8'hA5, v);
      ahb(1'b0, 32'h0000_0010, 8'h00, v); check(v, 8'h00);
      $display("test reset done");
      own = 7'($random(seed)) | 7'h08;
      wr(REG_ADDR, {own, 1'b1});
      wr(REG_CTRL, 8'h44);
      ahb(1'b0, ra(REG_ADDR), 8'h00, v); check(v, {own, 1'b1});
      // Slave transmit: two bytes, the second marked last, then extra clocks
      tws_master_model_i.start_c();
      tws_master_model_i.xfer({own, 1'b1}, 1'b1, rx, ak); check({7'h00, ak}, 8'h00);
      flag_status(ST_TX_OWN);
      d = 8'($random(seed)); wr(REG_DATA, d); wr(REG_CTRL, 8'hC4);
      tws_master_model_i.xfer(8'hFF, 1'b0, rx, ak); check(rx, d);
      flag_status(ST_TX_ACK);
      d = 8'($random(seed)); wr(REG_DATA, d); wr(REG_CTRL, 8'h84);
      tws_master_model_i.xfer(8'hFF, 1'b0, rx, ak); check(rx, d);
      flag_status(ST_TX_LAST);
      wr(REG_CTRL, 8'hC4);
      tws_master_model_i.xfer(8'hFF, 1'b1, rx, ak); check(rx, 8'hFF);
      tws_master_model_i.stop_c();
      $display("test slave transmit done");
      // General call in deep sleep, ack then nack, START queued on leaving
      @(posedge core_clk) deep_sleep <= 1'b1;
      tws_master_model_i.start_c();
      tws_master_model_i.xfer(8'h00, 1'b1, rx, ak); check({7'h00, ak}, 8'h00);
      flag_status(ST_RX_GC);
      check({7'h00, wake_req}, 8'h01);
      @(posedge core_clk) deep_sleep <= 1'b0;
      wr(REG_CTRL, 8'hC4);
      check({7'h00, wake_req}, 8'h00);
      d = 8'($random(seed));
      tws_master_model_i.xfer(d, 1'b1, rx, ak); check({7'h00, ak}, 8'h00);
      flag_status(ST_GC_ACK);
      ahb(1'b0, ra(REG_DATA), 8'h00, v); check(v, d);
      wr(REG_CTRL, 8'h84);
      tws_master_model_i.xfer(~d, 1'b1, rx, ak); check({7'h00, ak}, 8'h01);
      flag_status(ST_GC_NACK);
      wr(REG_CTRL, 8'hE4);
      tws_master_model_i.stop_c();
      repeat (20) @(posedge core_clk);
      check({7'h00, started}, 8'h01);
      wr(REG_CTRL, 8'h44);
      $display("test general call done");
      // Address hidden while ack_enable is zero, address nacked, then STOP while unaddressed
      wr(REG_CTRL, 8'h04);
      tws_master_model_i.start_c();
      tws_master_model_i.xfer({own, 1'b0}, 1'b1, rx, ak); check({7'h00, ak}, 8'h01);
      tws_master_model_i.stop_c();
      wr(REG_CTRL, 8'h44);
      // Own read after lost arbitration, first byte all ones so STOP can rise
      @(posedge core_clk) arb_lost <= 1'b1;
      tws_master_model_i.start_c();
      tws_master_model_i.xfer({own, 1'b1}, 1'b1, rx, ak); check({7'h00, ak}, 8'h00);
      flag_status(ST_TX_ARB);
      wr(REG_DATA, 8'hFF);
      wr(REG_CTRL, 8'hC4);
      tws_master_model_i.stop_c();
      flag_status(ST_STOP);
      wr(REG_CTRL, 8'hC4);
      $display("test stop while addressed done");
      print_verdict();
   end
endmodule : tb_two_wire_slave_rx_tx
`default_nettype wire
